// File: shared/btc_pkg.sv
// Constants and types shared by the burst trigger control block.
package btc_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] NCYC_OFS = 8'h04;
  localparam logic [7:0] PERIOD_OFS = 8'h08;
  localparam logic [7:0] PHASE_OFS = 8'h0c;
  localparam logic [7:0] CMD_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] PHDEG_OFS = 8'h18;
  // Field positions in the command register.
  localparam int CMD_TRIG = 0;
  localparam int CMD_BUSTRIG = 1;
  localparam int CMD_SETTINGS_A = 2;
  localparam int CMD_WAIT = 3;
  localparam int CMD_OPC = 4;
  localparam int CMD_OPCQ = 5;
  // Field positions in the status register.
  localparam int ST_BUSY = 0;
  localparam int ST_WAITBUS = 1;
  localparam int ST_OPCQ = 2;
  localparam int ST_OPCEV = 3;
  localparam int ST_WAITPEND = 4;
  localparam int ST_GATE = 5;
  // Burst cycle count limits and flag bit.
  localparam logic [15:0] NCYC_MIN = 16'h0001;
  localparam logic [15:0] NCYC_MAX = 16'hc350;
  localparam int NCYC_INF_BIT = 16;
  // Reset values.
  localparam logic [15:0] NCYC_RESET = 16'h0001;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  // Clock rate and the sync pulse width for bus triggering, strictly above 1 us.
  localparam int CLK_MHZ = 25;
  localparam int SYNC_PULSE_NS = 1000;
  localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * CLK_MHZ) / 1000 + 1;
  // Default repeat period in microseconds (10 ms).
  localparam int REPEAT_DEFAULT_US = 10000;
  localparam int REPEAT_DEFAULT_CYC = REPEAT_DEFAULT_US * CLK_MHZ;
  // Milliradian to degree scale factor, Q16.
  localparam logic signed [15:0] MRAD_TO_DEG_Q16 = 16'sh0eab;

  // Trigger source choices.
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_EXTERNAL = 2'b01,
    SRC_BUS = 2'b10
  } btc_src_type;

  // Burst engine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_STOPPING = 2'b10
  } btc_state_type;

  // Control register layout, low bit last.
  typedef struct packed {
    logic modulationEnable;
    logic sweepEnable;
    logic gatedMode;
    logic syncOutEnable;
    logic syncOutEdgeSelect;
    logic gateLevelPolarity;
    logic inputEdgeSelect;
    btc_src_type triggerSourceSelect;
    logic phaseUnitSelect;
    logic burstEnable;
  } btc_ctrl_type;

  localparam btc_ctrl_type CTRL_RESET = '{
    modulationEnable: 1'b0, sweepEnable: 1'b0, gatedMode: 1'b0,
    syncOutEnable: 1'b0, syncOutEdgeSelect: 1'b0, gateLevelPolarity: 1'b0,
    inputEdgeSelect: 1'b0, triggerSourceSelect: SRC_INTERNAL,
    phaseUnitSelect: 1'b0, burstEnable: 1'b0};
endpackage : btc_pkg

// File: src/btc_burst_trigger_control.sv
// Burst trigger control: APB registers, trigger selection, burst counting and sync out.
`timescale 1ns/100ps

// Notes on behaviour
// [R1] Burst off at reset; enabling clears sweep, modulation.
// [R2] Phase in degrees or radians; degrees readback.
// [R3] Each trigger outputs count cycles, then waits.
// [R4] Internal source repeats bursts every period.
// [R5] External edge starts burst; ignored while busy.
// [R6] Bus source: one burst per bus trigger.
// [R7] Waiting indicator while bus source idles.
// [R8] External/bus: count, phase kept; period ignored.
// [R9] Settings_a command resets source to internal.
// [R10] Wait command stalls commands until burst done.
// [R11] Completion answers pending OPC query, sets event.
// [R12] Input edge select: rising or falling, rising default.
// [R13] Gate polarity: true-high default, selectable.
// [R14] Sync edge marks each burst start when enabled.
// [R15] Internal source: sync square, half-period duty.
// [R16] External or gated: sync output forced off.
// [R17] Bus source: sync pulse above one microsecond.
// [R18] Sync enable off at reset, reads 0/1.
// [R19] Generic trigger launches under any source.
// [R20] Bus trigger acts only with bus source.
// [R21] Gated: run while true, finish cycle, hold.
// [R22] Count 1 to 50000 or infinite, default 1.
// [R23] Trigger pin synchronised and edge detected.
module btc_burst_trigger_control import btc_pkg::*; #(
  parameter logic [31:0] REPEAT_RESET = 32'(REPEAT_DEFAULT_CYC)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigInPin,
  input wire logic cycleEnd,
  output logic waveRun,
  output logic [15:0] startPhase,
  output logic phaseIsRadian,
  output logic syncOut,
  output logic syncOutOe,
  output logic sweepOn,
  output logic modulationOn,
  output logic waitingBus,
  output logic burstDone
);

  btc_ctrl_type ctrl; // Control settings.
  logic [15:0] burstCycleCount; // Cycles per burst.
  logic countInfinite; // Burst runs without end.
  logic [31:0] burstRepeatPeriod; // Repeat period in clock cycles.
  logic [15:0] burstStartPhase; // Signed phase, degrees or milliradians.
  btc_state_type state; // Burst engine state.
  logic [15:0] cyclesLeft; // Cycles still to output.
  logic [31:0] periodCount; // Repeat timer.
  logic [7:0] pulseCount; // Bus sync pulse timer.
  logic trigMeta; // First synchroniser stage.
  logic trigSync; // Second synchroniser stage.
  logic trigLast; // Previous synchronised level.
  logic waitPending; // Wait command held.
  logic opcQueryArmed; // Pending operation-complete query.
  logic opcQueryDone; // Query answer, reads 1 when done.
  logic opcCmdArmed; // Pending operation-complete command.
  logic opcEvent; // Event register bit 0.
  logic squareLevel; // Internal-source square wave.
  logic busPulse; // Bus-source sync pulse active.

  logic writeEn; // APB write strobe at the completing edge.
  logic stallSeen; // The bus was stalled by a wait at the previous edge.
  logic busy; // A burst is in progress.
  logic rawRise; // Synchronised rising edge.
  logic rawFall; // Synchronised falling edge.
  logic extEdge; // Edge of the selected polarity.
  logic gateTrue; // Gate level after polarity.
  logic periodTick; // Repeat timer expiry.
  logic cmdWrite; // Command register written.
  logic launch; // Burst start this cycle.
  logic finish; // Burst end this cycle.
  logic [31:0] next_prdata; // Read mux output.
  logic addrHit; // Address is mapped.

  // Converts the stored phase to whole degrees for display readback.
  function automatic logic [15:0] to_degrees(input logic [15:0] phase, input logic isRad);
    logic signed [31:0] product;
    product = 32'sh0;
    if (isRad) begin
      product = $signed(phase) * MRAD_TO_DEG_Q16;
      return product[31:16];
    end else begin
      return phase;
    end
  endfunction : to_degrees

  // Clamps a written count into the legal range.
  function automatic logic [15:0] clamp_count(input logic [15:0] value);
    if (value < NCYC_MIN) begin
      return NCYC_MIN;
    end else if (value > NCYC_MAX) begin
      return NCYC_MAX;
    end else begin
      return value;
    end
  endfunction : clamp_count

  // The wait command holds the bus until the running burst has ended, and one cycle more
  // so that read data is captured after the burst state has settled.
  assign pready = !(waitPending && busy) && !stallSeen; // [R10]
  assign writeEn = psel && penable && pready && pwrite;
  assign cmdWrite = writeEn && (paddr == CMD_OFS);
  assign busy = (state != ST_IDLE);

  // Decodes the mapped addresses for the error answer.
  always_comb begin
    case (paddr)
      CTRL_OFS, NCYC_OFS, PERIOD_OFS, PHASE_OFS, CMD_OFS, STATUS_OFS, PHDEG_OFS: begin
        addrHit = 1'b1;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  // Unmapped addresses answer with an error in the access phase.
  assign pslverr = psel && penable && !addrHit;

  // Control register; enabling burst switches sweep and modulation off.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET; // [R1] [R18]
    end else if (writeEn && paddr == CTRL_OFS) begin
      ctrl <= btc_ctrl_type'(pwdata[10:0]);
      if (pwdata[0]) begin
        ctrl.sweepEnable <= 1'b0; // [R1]
        ctrl.modulationEnable <= 1'b0; // [R1]
      end
      if (pwdata[3:2] == 2'b11) begin
        ctrl.triggerSourceSelect <= SRC_INTERNAL; // The unused code falls back to internal.
      end
    end else if (cmdWrite && pwdata[CMD_SETTINGS_A]) begin
      ctrl.triggerSourceSelect <= SRC_INTERNAL; // [R9]
    end
  end

  // Count, period and phase registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burstCycleCount <= NCYC_RESET; // [R22]
      countInfinite <= 1'b0;
      burstRepeatPeriod <= REPEAT_RESET;
      burstStartPhase <= PHASE_RESET;
    end else if (writeEn) begin
      if (paddr == NCYC_OFS) begin
        burstCycleCount <= clamp_count(pwdata[15:0]); // [R22]
        countInfinite <= pwdata[NCYC_INF_BIT];
      end
      if (paddr == PERIOD_OFS) begin
        // A zero period would never tick, so it is raised to one cycle.
        burstRepeatPeriod <= (pwdata == 32'h0) ? 32'h1 : pwdata;
      end
      if (paddr == PHASE_OFS) begin
        burstStartPhase <= pwdata[15:0]; // [R2]
      end
    end
  end

  // Two flip-flops bring the trigger pin into the clock domain.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trigMeta <= 1'b0;
      trigSync <= 1'b0;
      trigLast <= 1'b0;
    end else begin
      trigMeta <= trigInPin; // [R23]
      trigSync <= trigMeta; // [R23]
      trigLast <= trigSync; // [R23]
    end
  end

  // One-cycle edges and the polarity-corrected gate level.
  assign rawRise = trigSync && !trigLast; // [R23]
  assign rawFall = !trigSync && trigLast; // [R23]
  assign extEdge = ctrl.inputEdgeSelect ? rawFall : rawRise; // [R12]
  assign gateTrue = ctrl.gateLevelPolarity ? !trigSync : trigSync; // [R13]

  // Repeat timer; only the internal source looks at the period.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periodCount <= 32'h0;
    end else if (!ctrl.burstEnable || ctrl.gatedMode
                 || ctrl.triggerSourceSelect != SRC_INTERNAL) begin
      periodCount <= 32'h0; // [R8]
    end else if (launch || periodCount == burstRepeatPeriod - 32'h1) begin
      periodCount <= 32'h0; // [R4]
    end else begin
      periodCount <= periodCount + 32'h1;
    end
  end

  assign periodTick = ctrl.triggerSourceSelect == SRC_INTERNAL
                      && periodCount == burstRepeatPeriod - 32'h1; // [R4]

  // Accepted triggers; any trigger while a burst runs is dropped.
  always_comb begin
    launch = 1'b0;
    if (ctrl.burstEnable && !ctrl.gatedMode && !busy) begin // [R5]
      if (cmdWrite && pwdata[CMD_TRIG]) begin
        launch = 1'b1; // [R19]
      end
      if (cmdWrite && pwdata[CMD_BUSTRIG] && ctrl.triggerSourceSelect == SRC_BUS) begin
        launch = 1'b1; // [R6] [R20]
      end
      if (extEdge && ctrl.triggerSourceSelect == SRC_EXTERNAL) begin
        launch = 1'b1; // [R5]
      end
      if (periodTick) begin
        launch = 1'b1; // [R4]
      end
    end
    if (ctrl.burstEnable && ctrl.gatedMode && !busy && gateTrue) begin
      launch = 1'b1; // [R21]
    end
  end

  // Burst engine: counts waveform cycles or follows the gate.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cyclesLeft <= 16'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            state <= ST_RUN;
            cyclesLeft <= burstCycleCount; // [R3]
          end
        end
        ST_RUN: begin
          if (!ctrl.burstEnable) begin
            state <= ST_STOPPING; // Leaving burst mode still ends on a cycle edge.
          end else if (ctrl.gatedMode) begin
            if (!gateTrue) begin
              state <= cycleEnd ? ST_IDLE : ST_STOPPING; // [R21]
            end
          end else if (cycleEnd && !countInfinite) begin
            cyclesLeft <= cyclesLeft - 16'h1;
            if (cyclesLeft == 16'h1) begin
              state <= ST_IDLE; // [R3]
            end
          end
        end
        ST_STOPPING: begin
          if (cycleEnd) begin
            state <= ST_IDLE; // [R21]
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Burst end, as seen by the completion logic.
  assign finish = busy && (
    (state == ST_STOPPING && cycleEnd)
    || (state == ST_RUN && ctrl.burstEnable && ctrl.gatedMode && !gateTrue && cycleEnd)
    || (state == ST_RUN && ctrl.burstEnable && !ctrl.gatedMode && cycleEnd
        && !countInfinite && cyclesLeft == 16'h1));

  // Wait and operation-complete bookkeeping; a set beats a clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitPending <= 1'b0;
      opcQueryArmed <= 1'b0;
      opcQueryDone <= 1'b0;
      opcCmdArmed <= 1'b0;
      opcEvent <= 1'b0;
    end else begin
      if (cmdWrite && pwdata[CMD_WAIT]) begin
        waitPending <= 1'b1; // [R10]
      end else if (!busy) begin
        waitPending <= 1'b0; // [R10]
      end
      if (cmdWrite && pwdata[CMD_OPCQ]) begin
        opcQueryArmed <= busy;
        opcQueryDone <= !busy; // [R11]
      end else if (opcQueryArmed && (finish || !busy)) begin
        opcQueryArmed <= 1'b0;
        opcQueryDone <= 1'b1; // [R11]
      end
      if (cmdWrite && pwdata[CMD_OPC]) begin
        opcCmdArmed <= busy;
      end else if (opcCmdArmed && (finish || !busy)) begin
        opcCmdArmed <= 1'b0;
      end
      if ((opcCmdArmed && (finish || !busy)) || (cmdWrite && pwdata[CMD_OPC] && !busy)) begin
        opcEvent <= 1'b1; // [R11]
      end else if (writeEn && paddr == STATUS_OFS && pwdata[ST_OPCEV]) begin
        opcEvent <= 1'b0;
      end
    end
  end

  // Sync sources: a square wave for internal repeat, a pulse for bus triggers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      squareLevel <= 1'b0;
      pulseCount <= 8'h0;
      busPulse <= 1'b0;
    end else begin
      if (launch) begin
        squareLevel <= 1'b1; // [R14]
      end else if (periodCount == (burstRepeatPeriod >> 1) - 32'h1) begin
        squareLevel <= 1'b0; // [R15]
      end
      if (launch && ctrl.triggerSourceSelect == SRC_BUS) begin
        busPulse <= 1'b1; // [R17]
        pulseCount <= 8'(SYNC_PULSE_CYC - 1);
      end else if (pulseCount != 8'h0) begin
        pulseCount <= pulseCount - 8'h1;
      end else begin
        busPulse <= 1'b0; // [R17]
      end
    end
  end

  // Drives the shared sync connector, or releases it to the trigger input.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncOut <= 1'b0;
      syncOutOe <= 1'b0;
    end else if (!ctrl.syncOutEnable || ctrl.gatedMode
                 || ctrl.triggerSourceSelect == SRC_EXTERNAL) begin
      syncOut <= 1'b0; // [R16] [R18]
      syncOutOe <= 1'b0; // [R16]
    end else begin
      syncOutOe <= 1'b1;
      if (ctrl.triggerSourceSelect == SRC_INTERNAL) begin
        syncOut <= squareLevel ^ ctrl.syncOutEdgeSelect; // [R14] [R15]
      end else begin
        syncOut <= busPulse ^ ctrl.syncOutEdgeSelect; // [R14] [R17]
      end
    end
  end

  // Read multiplexer.
  always_comb begin
    case (paddr)
      CTRL_OFS: next_prdata = {21'h0, ctrl};
      NCYC_OFS: next_prdata = {15'h0, countInfinite, burstCycleCount};
      PERIOD_OFS: next_prdata = burstRepeatPeriod;
      PHASE_OFS: next_prdata = {16'h0, burstStartPhase};
      STATUS_OFS: next_prdata = {26'h0, gateTrue, waitPending, opcEvent, opcQueryDone,
                                 waitingBus, busy};
      PHDEG_OFS: next_prdata = {16'h0, to_degrees(burstStartPhase, ctrl.phaseUnitSelect)}; // [R2]
      default: next_prdata = 32'h0;
    endcase
  end

  // Read data is captured in setup and in each stalled access cycle, so a registered
  // value stands at the completing edge; it then holds until the next read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      stallSeen <= 1'b0;
    end else begin
      stallSeen <= waitPending && busy; // [R10]
      if (psel && !pwrite && !(penable && pready)) begin
        prdata <= next_prdata;
      end
    end
  end

  // Registered status outputs toward the synthesiser and panel.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitingBus <= 1'b0;
      burstDone <= 1'b0;
    end else begin
      waitingBus <= ctrl.burstEnable && !ctrl.gatedMode
                    && ctrl.triggerSourceSelect == SRC_BUS && !busy && !launch; // [R7]
      burstDone <= finish;
    end
  end

  // The synthesiser runs while a burst is active and holds the start phase otherwise.
  assign waveRun = busy; // [R3] [R21]
  assign startPhase = burstStartPhase; // [R8]
  assign phaseIsRadian = ctrl.phaseUnitSelect; // [R2]
  assign sweepOn = ctrl.sweepEnable;
  assign modulationOn = ctrl.modulationEnable;

endmodule : btc_burst_trigger_control

// File: verification/btc_wave_partner.sv
// Waveform synthesiser stand-in that marks the end of every output cycle.
`timescale 1ns/100ps
module btc_wave_partner #(
  parameter int CYC = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic waveRun,
  output logic cycleEnd
);
  logic [7:0] phaseCnt; // Clocks spent in the current waveform cycle.

  // The count restarts at each launch, so every burst begins at phase zero.
  // A real synthesiser may be mid-cycle here; this one is deliberately regular.
  always_ff @(posedge clk) begin
    if (sys_rst || !waveRun) begin
      phaseCnt <= 8'h00;
      cycleEnd <= 1'b0;
    end else begin
      cycleEnd <= (phaseCnt == 8'(CYC - 2));
      phaseCnt <= (phaseCnt == 8'(CYC - 1)) ? 8'h00 : phaseCnt + 8'h01;
    end
  end
endmodule : btc_wave_partner

// File: verification/btc_asserts.sv
// Concurrent checks on the ports of the burst trigger control block.
`timescale 1ns/100ps
module btc_asserts import btc_pkg::*; #(
  parameter logic [31:0] REPEAT_RESET = 32'd100
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic cycleEnd,
  input wire logic waveRun,
  input wire logic phaseIsRadian,
  input wire logic syncOut,
  input wire logic syncOutOe,
  input wire logic sweepOn,
  input wire logic modulationOn,
  input wire logic waitingBus,
  input wire logic burstDone
);
  // A write lands only at the edge where the access phase meets ready.
  wire logic wrEdge = psel && penable && pready && pwrite;
  wire logic ctrlWr = wrEdge && (paddr == CTRL_OFS);
  wire logic cmdWr = wrEdge && (paddr == CMD_OFS);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  burst_clears_mod_a:
    assert property (ctrlWr && pwdata[0] |=> !sweepOn && !modulationOn)
    else $error("Sweep or modulation still on after burst enable.");
  unit_follows_a:
    assert property (ctrlWr |=> phaseIsRadian == $past(pwdata[1]))
    else $error("Phase unit output does not follow the written bit.");
  end_on_cycle_a:
    assert property ($fell(waveRun) |-> $past(cycleEnd))
    else $error("Burst stopped away from a waveform cycle end.");
  done_follows_a:
    assert property ($fell(waveRun) |-> ##[0:1] burstDone)
    else $error("No completion pulse after a burst.");
  done_single_a:
    assert property (burstDone |=> !burstDone)
    else $error("Completion pulse longer than one clock.");
  bus_launch_a:
    assert property (cmdWr && pwdata[CMD_BUSTRIG] && waitingBus |=> waveRun)
    else $error("Bus trigger did not launch a burst.");
  wait_lamp_a:
    assert property (waveRun && $past(waveRun) |-> !waitingBus)
    else $error("Waiting indicator lit during a burst.");
  settings_a_src_a:
    assert property (cmdWr && pwdata[CMD_SETTINGS_A] |-> ##2 !waitingBus)
    else $error("Settings_a left the bus source selected.");
  stall_busy_a:
    assert property (!pready |-> waveRun || $past(waveRun))
    else $error("Bus stalled with no burst running.");
  sync_quiet_a:
    assert property (!syncOutOe |-> !syncOut)
    else $error("Sync data high while not driven.");

  // Main scenarios that should be seen at least once.
  cover property ($rose(waveRun));
  cover property (!pready);
  cover property (ctrlWr && pwdata[8]);
endmodule : btc_asserts

bind btc_burst_trigger_control btc_asserts #(.REPEAT_RESET(REPEAT_RESET)) u_asserts (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .cycleEnd(cycleEnd),
  .waveRun(waveRun), .phaseIsRadian(phaseIsRadian), .syncOut(syncOut),
  .syncOutOe(syncOutOe), .sweepOn(sweepOn), .modulationOn(modulationOn),
  .waitingBus(waitingBus), .burstDone(burstDone));

// File: verification/btc_burst_trigger_control_tb_top.sv
// Self-checking bench for the burst trigger control block.
`timescale 1ns/100ps
module btc_burst_trigger_control_tb_top import btc_pkg::*; ;
  logic clk, sys_rst, psel, penable, pwrite, trigInPin, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] startPhase;
  logic pready, pslverr, cycleEnd, waveRun, phaseIsRadian, syncOut, syncOutOe;
  logic sweepOn, modulationOn, waitingBus, burstDone;
  int errors, nCompared, c, n, h, g, c1;

  // A short repeat period keeps the internal source test brief.
  btc_burst_trigger_control #(.REPEAT_RESET(32'd100)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigInPin(trigInPin), .cycleEnd(cycleEnd), .waveRun(waveRun),
    .startPhase(startPhase), .phaseIsRadian(phaseIsRadian), .syncOut(syncOut),
    .syncOutOe(syncOutOe), .sweepOn(sweepOn), .modulationOn(modulationOn),
    .waitingBus(waitingBus), .burstDone(burstDone));
  btc_wave_partner #(.CYC(10)) u_wave (
    .clk(clk), .sys_rst(sys_rst), .waveRun(waveRun), .cycleEnd(cycleEnd));

  // The 25 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // One comparison with four-state equality so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; returns at the completing edge with data and error taken.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 3000);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 3000) begin
      errors++;
      give_verdict();
    end
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdchk

  // Waits up to lim clocks for a burst, then measures its length, cycle ends
  // and sync-high clocks; c stays 0 when no burst came.
  task automatic meas(input int lim, output int c, output int n, output int h,
                      output int g);
    c = 0;
    n = 0;
    h = 0;
    g = 0;
    while (waveRun !== 1'b1 && g < lim) begin
      @(posedge clk);
      g++;
    end
    while (waveRun === 1'b1 && c < 3000) begin
      n += int'(cycleEnd);
      h += int'(syncOut);
      c++;
      @(posedge clk);
    end
    if (c >= 3000) begin
      errors++;
      give_verdict();
    end
  endtask : meas

  task automatic t_reset();
    rdchk(CTRL_OFS, 32'h0);
    rdchk(NCYC_OFS, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    chk(syncOutOe, 1'b0);
  endtask : t_reset

  task automatic t_config();
    logic [31:0] ncIn[3];
    logic [31:0] ncOut[3];
    ncIn = '{32'h0, 32'hc350, 32'hea60};
    ncOut = '{32'h1, 32'hc350, 32'hc350};
    apb(1'b1, CTRL_OFS, 32'h200);
    @(posedge clk);
    chk(sweepOn, 1'b1);
    // External source with an idle pin, so no burst starts here.
    apb(1'b1, CTRL_OFS, 32'h605);
    @(posedge clk);
    chk({sweepOn, modulationOn}, 2'b00);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, NCYC_OFS, ncIn[i]);
      rdchk(NCYC_OFS, ncOut[i]);
    end
    apb(1'b1, CTRL_OFS, 32'h2);
    apb(1'b1, PHASE_OFS, 32'd1000);
    rdchk(PHDEG_OFS, 32'h39);
    chk(phaseIsRadian, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h8);
    apb(1'b1, CMD_OFS, 32'h4);
    rdchk(CTRL_OFS, 32'h0);
  endtask : t_config

  task automatic t_bus();
    apb(1'b1, PHASE_OFS, 32'h5a);
    apb(1'b1, NCYC_OFS, 32'h3);
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, CTRL_OFS, 32'h89 | (32'(e) << 6));
      repeat (2) @(posedge clk);
      chk(waitingBus, 1'b1);
      apb(1'b1, CMD_OFS, 32'h2);
      chk(startPhase, 16'h5a);
      meas(10, c, n, h, g);
      chk(burstDone, 1'b1);
      chk(n, 3);
      chk(c, 30);
      chk(h, e ? 30 - SYNC_PULSE_CYC : SYNC_PULSE_CYC);
    end
    apb(1'b1, CTRL_OFS, 32'h89);
    apb(1'b1, CMD_OFS, 32'h2);
    apb(1'b1, CMD_OFS, 32'h30);
    apb(1'b1, CMD_OFS, 32'h8);
    // The wait stalls this read until the burst is over; the wait is still shown pending.
    rdchk(STATUS_OFS, 32'h1c);
    chk(waveRun, 1'b0);
    meas(300, c, n, h, g);
    chk(c, 0);
  endtask : t_bus

  task automatic t_ext();
    apb(1'b1, CTRL_OFS, 32'h85);
    repeat (2) @(posedge clk);
    chk(syncOutOe, 1'b0);
    apb(1'b1, CMD_OFS, 32'h2);
    meas(40, c, n, h, g);
    chk(c, 0);
    apb(1'b1, CMD_OFS, 32'h1);
    meas(10, c, n, h, g);
    chk(c, 30);
    trigInPin <= 1'b1;
    meas(10, c, n, h, g);
    chk(c, 30);
    trigInPin <= 1'b0;
    apb(1'b1, CMD_OFS, 32'h1);
    // This rising edge arrives mid-burst and must be dropped.
    trigInPin <= 1'b1;
    meas(10, c, n, h, g);
    meas(60, c, n, h, g);
    chk(c, 0);
    apb(1'b1, CTRL_OFS, 32'h95);
    trigInPin <= 1'b0;
    meas(10, c, n, h, g);
    chk(c, 30);
    trigInPin <= 1'b1;
    meas(40, c, n, h, g);
    chk(c, 0);
  endtask : t_ext

  task automatic t_gate();
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      trigInPin <= p[0];
      apb(1'b1, CTRL_OFS, 32'h181 | (32'(p) << 5));
      repeat (14) @(posedge clk);
      chk(waveRun, 1'b0);
      chk(syncOutOe, 1'b0);
      trigInPin <= ~p[0];
      repeat (25) @(posedge clk);
      chk(waveRun, 1'b1);
      trigInPin <= p[0];
      repeat (20) @(posedge clk);
      chk(waveRun, 1'b0);
    end
  endtask : t_gate

  task automatic t_int();
    apb(1'b1, PERIOD_OFS, 32'd100);
    apb(1'b1, CTRL_OFS, 32'h81);
    meas(300, c1, n, h, g);
    meas(300, c, n, h, g);
    chk(c1 + g, 100);
    h = 0;
    repeat (100) begin
      @(posedge clk);
      h += int'(syncOut);
    end
    chk(h, 50);
    chk(syncOutOe, 1'b1);
  endtask : t_int

  // Main sequence: hold reset for 8 clocks, then run every scenario.
  initial begin
    errors = 0;
    nCompared = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trigInPin = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_config();
    t_bus();
    t_ext();
    t_gate();
    t_int();
    give_verdict();
  end
endmodule : btc_burst_trigger_control_tb_top
